// file: logic/dcr_bank.sv
// What this block does
// - Writes to the no-operation register are dropped and it always reads zero.
// - The DAC output code register is 16-bit read-write, resets to zero and drives the output code.
// - Frame fault status sets only after 1, 2, 4 or 8 consecutive failed frames, per bits 15-14.
// - Bits 13-10 pick the clock output divisor of the oscillator, code 0 switching it off.
// - Codes C to E hold the clock output low and code F routes the timer to it.
// - Bit 9 lets interrupts go out on the UART transmit line in break mode.
// - The interrupt pin is driven only while bit 8 is set.
// - Bit 7 lets the clear pin, or SDI in break mode, request the clear state.
// - Bit 6 switches the UART off; clear keeps it on.
// - Bit 4 turns frame checking on for SPI transfers and is on after reset.
// - Bit 3 selects interrupt polarity, low active when clear.
// - Bit 2 selects level interrupts when set and edge pulses when clear.
// - Bit 1 set keeps SDO floating; clear drives SDO while chip select is low.
// - Bit 0 selects SDO launch on the falling edge instead of the rising edge.
// - The setup register resets to 0036h.
//
// Purpose: APB register bank holding code and setup registers plus pin side effects.
// Assumes: Pins are asynchronous to sys_clk_in; frame check results arrive as pins too.
// Notes: pready is high in every access phase, so each transfer takes two cycles.
`timescale 1ns/1ps
`default_nettype none
module dcr_bank (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [9:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic osc_tick_in,
  input wire logic timer_in,
  input wire logic frame_done_in,
  input wire logic frame_bad_in,
  input wire logic spi_clear_pin_in,
  input wire logic sdi_in,
  input wire logic cs_n_in,
  input wire logic uart_break_mode_in,
  input wire logic ext_event_in,
  input wire logic spi_sdo_in,
  output logic [15:0] dac_code_out,
  output logic clk_out,
  output logic irq_out,
  output logic irq_oe_n_out,
  output logic uart_tx_pin_out,
  output logic async_port_off_out,
  output logic frame_check_on_out,
  output logic clear_req_out,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  output logic sdo_early_out,
  output logic int_out
);
  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Two flop synchronisers for every pin; only the second stage is read
  logic [dcr_pkg::NUM_SYNC-1:0] pin_raw;
  logic [dcr_pkg::NUM_SYNC-1:0] sync1_q;
  logic [dcr_pkg::NUM_SYNC-1:0] sync2_q;
  assign pin_raw = {osc_tick_in, timer_in, frame_done_in, frame_bad_in, spi_clear_pin_in,
                    sdi_in, cs_n_in, uart_break_mode_in};
  genvar gi;
  generate
    for (gi = 0; gi < dcr_pkg::NUM_SYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  logic osc_s;
  logic timer_s;
  logic fdone_s;
  logic fbad_s;
  logic spi_clear_pin_s;
  logic sdi_s;
  logic cs_n_s;
  logic brk_s;
  assign {osc_s, timer_s, fdone_s, fbad_s, spi_clear_pin_s, sdi_s, cs_n_s, brk_s} = sync2_q;

  // Extra event and SDO pins share the same two-stage treatment
  logic [1:0] ext_sync_q;
  logic [1:0] sdo_sync_q;
  logic osc_prev_q;
  logic fdone_prev_q;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_q <= 2'b00;
      sdo_sync_q <= 2'b00;
      osc_prev_q <= 1'b0;
      fdone_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_event_in};
      sdo_sync_q <= {sdo_sync_q[0], spi_sdo_in};
      osc_prev_q <= osc_s;
      fdone_prev_q <= fdone_s;
    end
  end

  // APB decode
  logic [7:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic hit_nop;
  logic hit_code;
  logic hit_setup;
  logic hit_stat;
  logic hit_mask;
  logic hit_pins;
  logic mapped;
  assign idx = paddr_in[9:2];
  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign rd_acc = psel_in && penable_in && !pwrite_in;
  assign hit_nop = idx == dcr_pkg::IDX_NOP;
  assign hit_code = idx == dcr_pkg::IDX_DAC_CODE;
  assign hit_setup = idx == dcr_pkg::IDX_SETUP;
  assign hit_stat = idx == dcr_pkg::IDX_IRQ_STATUS;
  assign hit_mask = idx == dcr_pkg::IDX_IRQ_MASK;
  assign hit_pins = idx == dcr_pkg::IDX_PIN_STATE;
  assign mapped = (hit_nop || hit_code || hit_setup || hit_stat || hit_mask || hit_pins) &&
                  paddr_in[1:0] == 2'b00;

  // Registers
  logic [15:0] code_q;
  logic [15:0] setup_q;
  logic [15:0] setup_d;
  logic [3:0] mask_q;
  logic [3:0] stat_q;
  logic [3:0] stat_set;
  assign setup_d = {pwdata_in[15:6], 1'b1, pwdata_in[4:0]};
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= dcr_pkg::RST_DAC_CODE;
      setup_q <= dcr_pkg::RST_SETUP;
      mask_q <= dcr_pkg::RST_IRQ_MASK;
    end else begin
      if (wr_acc && mapped && hit_code) code_q <= pwdata_in[15:0];
      if (wr_acc && mapped && hit_setup) setup_q <= setup_d;
      if (wr_acc && mapped && hit_mask) mask_q <= pwdata_in[3:0];
    end
  end

  // Setup field views
  logic [1:0] thr_sel;
  logic [3:0] div_code;
  logic brk_irq_en;
  logic irq_pin_en;
  logic clr_en;
  logic frame_chk;
  logic interrupt_polarity;
  logic interrupt_trigger_type;
  assign thr_sel = setup_q[dcr_pkg::FLD_FAULT_THR_LO +: 2];
  assign div_code = setup_q[dcr_pkg::FLD_CLKDIV_LO +: 4];
  assign brk_irq_en = setup_q[dcr_pkg::FLD_BRK_IRQ_EN];
  assign irq_pin_en = setup_q[dcr_pkg::FLD_IRQ_PIN_EN];
  assign clr_en = setup_q[dcr_pkg::FLD_CLR_EN];
  assign frame_chk = setup_q[dcr_pkg::FLD_FRAME_CHK];
  assign interrupt_polarity = setup_q[dcr_pkg::FLD_INTERRUPT_POLARITY];
  assign interrupt_trigger_type = setup_q[dcr_pkg::FLD_IRQ_TRIG];

  // Consecutive bad frame counter; a good frame restarts the run
  logic [3:0] bad_run_q;
  logic [3:0] bad_run_d;
  logic [3:0] bad_limit;
  logic frame_end;
  logic fault_hit;
  assign frame_end = fdone_s && !fdone_prev_q;
  assign bad_limit = 4'h1 << thr_sel;
  assign fault_hit = frame_end && frame_chk && fbad_s && (bad_run_q + 4'h1 >= bad_limit);
  always_comb begin
    bad_run_d = bad_run_q;
    if (frame_end && frame_chk) begin
      if (!fbad_s) bad_run_d = 4'h0;
      else if (fault_hit) bad_run_d = 4'h0;
      else bad_run_d = bad_run_q + 4'h1;
    end
  end

  // Clear request: SPI_CLEAR_PIN in SPI mode, SDI in break mode
  logic clr_src;
  logic clr_req_d;
  assign clr_src = brk_s ? sdi_s : spi_clear_pin_s;
  assign clr_req_d = clr_en && clr_src;
  logic clr_prev_q;

  // Sticky status, read clears, set wins over clear
  logic stat_rd;
  logic [3:0] stat_clr;
  assign stat_rd = rd_acc && mapped && hit_stat;
  // Clear only what the read returned, so an event landing at the setup edge is not lost
  assign stat_clr = stat_rd ? prdata_out[3:0] : 4'h0;
  assign stat_set[dcr_pkg::ST_FRAME_FAULT] = fault_hit;
  assign stat_set[dcr_pkg::ST_CLEAR_REQ] = clr_req_d && !clr_prev_q;
  assign stat_set[dcr_pkg::ST_EXT_EVENT] = ext_sync_q[1];
  assign stat_set[dcr_pkg::ST_WRITE_NOP] = wr_acc && mapped && hit_nop;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 4'h0;
      bad_run_q <= 4'h0;
      clr_prev_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      bad_run_q <= bad_run_d;
      clr_prev_q <= clr_req_d;
    end
  end

  // Interrupt conditioning: level mode follows, edge mode pulses once each time the pending flag rises
  logic irq_pend;
  logic irq_pend_prev_q;
  logic irq_act;
  assign irq_pend = |(stat_q & mask_q);
  assign irq_act = interrupt_trigger_type ? irq_pend : (irq_pend && !irq_pend_prev_q);

  // Read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_nop) rd_data = 32'h0000_0000;
    else if (hit_code) rd_data = {16'h0000, code_q};
    else if (hit_setup) rd_data = {16'h0000, setup_q};
    else if (hit_stat) rd_data = {28'h0000000, stat_q};
    else if (hit_mask) rd_data = {28'h0000000, mask_q};
    else if (hit_pins) rd_data = {27'h0000000, clr_prev_q, brk_s, cs_n_s, bad_run_q[1:0]};
  end

  // Clock output divider
  dcr_cfg_if cfg ();
  assign cfg.div_code = div_code;
  assign cfg.osc_tick = osc_s && !osc_prev_q;
  assign cfg.timer_level = timer_s;
  dcr_clk_div u_div (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .cfg(cfg.divider)
  );

  // All outputs registered
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      dac_code_out <= dcr_pkg::RST_DAC_CODE;
      clk_out <= 1'b0;
      irq_out <= 1'b1; // Inactive level for the low-active reset polarity
      irq_oe_n_out <= 1'b1;
      uart_tx_pin_out <= 1'b1;
      async_port_off_out <= 1'b0;
      frame_check_on_out <= 1'b1;
      clear_req_out <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe_n_out <= 1'b1;
      sdo_early_out <= 1'b0;
      int_out <= 1'b0;
      irq_pend_prev_q <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      prdata_out <= (psel_in && !penable_in && !pwrite_in) ? rd_data : 32'h0000_0000;
      dac_code_out <= code_q;
      clk_out <= cfg.clk_level;
      irq_out <= irq_act ^ !interrupt_polarity;
      irq_oe_n_out <= !irq_pin_en;
      uart_tx_pin_out <= !(brk_irq_en && brk_s && irq_act);
      async_port_off_out <= setup_q[dcr_pkg::FLD_ASYNC_OFF];
      frame_check_on_out <= frame_chk;
      clear_req_out <= clr_req_d;
      sdo_out <= sdo_sync_q[1];
      sdo_oe_n_out <= setup_q[dcr_pkg::FLD_SDO_TRI] || cs_n_s;
      sdo_early_out <= setup_q[dcr_pkg::FLD_SDO_EARLY];
      int_out <= irq_pend;
      irq_pend_prev_q <= irq_pend;
    end
  end
endmodule : dcr_bank
`default_nettype wire

// file: pkg/dcr_pkg.sv
// Purpose: Shared constants for the converter setup register bank.
// Assumes: APB slave with 32-bit data, 16-bit registers in the low half of each word.
// Notes: Printed offsets are word indexes; byte address is four times the index.
`default_nettype none
package dcr_pkg;
  // Register indexes as printed
  localparam logic [7:0] IDX_NOP = 8'h00;
  localparam logic [7:0] IDX_DAC_CODE = 8'h01;
  localparam logic [7:0] IDX_SETUP = 8'h02;
  // Extra registers of this bank
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
  localparam logic [7:0] IDX_PIN_STATE = 8'h12;
  // Reset values
  localparam logic [15:0] RST_DAC_CODE = 16'h0000;
  localparam logic [15:0] RST_SETUP = 16'h0036;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  // Setup field positions
  localparam int FLD_FAULT_THR_LO = 14;
  localparam int FLD_CLKDIV_LO = 10;
  localparam int FLD_BRK_IRQ_EN = 9;
  localparam int FLD_IRQ_PIN_EN = 8;
  localparam int FLD_CLR_EN = 7;
  localparam int FLD_ASYNC_OFF = 6;
  localparam int FLD_RSVD_ONE = 5;
  localparam int FLD_FRAME_CHK = 4;
  localparam int FLD_INTERRUPT_POLARITY = 3;
  localparam int FLD_IRQ_TRIG = 2;
  localparam int FLD_SDO_TRI = 1;
  localparam int FLD_SDO_EARLY = 0;
  // Interrupt status bit positions
  localparam int ST_FRAME_FAULT = 0;
  localparam int ST_CLEAR_REQ = 1;
  localparam int ST_EXT_EVENT = 2;
  localparam int ST_WRITE_NOP = 3;
  // Clock output codes
  localparam logic [3:0] CLKDIV_OFF = 4'h0;
  localparam logic [3:0] CLKDIV_TIMER = 4'hf;
  localparam logic [3:0] CLKDIV_LAST = 4'hb;
  // Pins resynchronised into the clock domain
  localparam int NUM_SYNC = 8;
endpackage : dcr_pkg
`default_nettype wire

// file: pkg/dcr_cfg_if.sv
// Purpose: Setup fields carried from the register bank to the clock output divider.
// Assumes: Single clock domain.
// Notes: The bank drives div_code, osc_tick and timer_level; the divider reads them and drives clk_level back.
`timescale 1ns/1ps
`default_nettype none
interface dcr_cfg_if;
  logic [3:0] div_code;
  logic osc_tick;
  logic timer_level;
  logic clk_level;
  modport bank (output div_code, output osc_tick, output timer_level, input clk_level);
  modport divider (input div_code, input osc_tick, input timer_level, output clk_level);
endinterface : dcr_cfg_if
`default_nettype wire

// file: logic/dcr_clk_div.sv
// Purpose: Divides the oscillator tick into the clock output pin level.
// Assumes: osc_tick pulses once per oscillator period.
// Notes: Divider table kept exactly as programmed, including the repeated 128.
`timescale 1ns/1ps
`default_nettype none
module dcr_clk_div (
  input wire logic clk_in,
  input wire logic rst_n_in,
  dcr_cfg_if.divider cfg
);
  logic [10:0] div_ratio;
  logic [10:0] half_cnt_q;
  logic [10:0] half_cnt_d;
  logic level_q;
  logic level_d;
  logic toggle;
  // Divisor per code; code 1 toggles each tick like code 2, giving half the tick rate
  always_comb begin
    case (cfg.div_code)
      4'h1: div_ratio = 11'h001;
      4'h2: div_ratio = 11'h002;
      4'h3: div_ratio = 11'h004;
      4'h4: div_ratio = 11'h008;
      4'h5: div_ratio = 11'h010;
      4'h6: div_ratio = 11'h020;
      4'h7: div_ratio = 11'h030;
      4'h8: div_ratio = 11'h080;
      4'h9: div_ratio = 11'h080;
      4'ha: div_ratio = 11'h200;
      4'hb: div_ratio = 11'h400;
      default: div_ratio = 11'h001;
    endcase
  end
  // Toggle every half period counted in oscillator ticks (divisor 1 toggles each tick)
  assign toggle = cfg.osc_tick && ((half_cnt_q + 11'h001) >= (div_ratio >> 1) ||
                  div_ratio == 11'h001);
  assign half_cnt_d = !cfg.osc_tick ? half_cnt_q : (toggle ? 11'h000 : half_cnt_q + 11'h001);
  // Codes C..E force low, F selects timer, 0 disables
  always_comb begin
    if (cfg.div_code == dcr_pkg::CLKDIV_OFF || cfg.div_code > dcr_pkg::CLKDIV_LAST) begin
      level_d = 1'b0;
    end else begin
      level_d = toggle ? !level_q : level_q;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      half_cnt_q <= 11'h000;
      level_q <= 1'b0;
    end else begin
      half_cnt_q <= half_cnt_d;
      level_q <= level_d;
    end
  end
  assign cfg.clk_level = (cfg.div_code == dcr_pkg::CLKDIV_TIMER) ? cfg.timer_level : level_q;
endmodule : dcr_clk_div
`default_nettype wire

// file: tb/dcr_bank_asserts.sv
// Purpose: Port-level checks of the converter setup bank.
// Assumes: One clock; the setup word is shadowed from APB writes.
// Notes: Setup outputs are compared only once a write is three cycles old.
`timescale 1ns/1ps
`default_nettype none
module dcr_bank_asserts (
  input wire logic sys_clk_in, input wire logic nrst_in,
  input wire logic psel_in, input wire logic penable_in, input wire logic pwrite_in,
  input wire logic [9:0] paddr_in, input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out, input wire logic pready_out,
  input wire logic pslverr_out, input wire logic [15:0] dac_code_out,
  input wire logic clk_out, input wire logic irq_out, input wire logic irq_oe_n_out,
  input wire logic uart_tx_pin_out, input wire logic async_port_off_out,
  input wire logic frame_check_on_out, input wire logic sdo_oe_n_out,
  input wire logic sdo_early_out
);
  logic [15:0] cfg_q;
  logic [1:0] age_q;
  logic acc;
  logic wr_cfg;
  logic ok;
  // Completed access and setup write decode
  assign acc = psel_in && penable_in && pready_out;
  assign wr_cfg = acc && pwrite_in && paddr_in == 10'h008;
  assign ok = age_q == 2'd3;
  // Shadow setup word; the age hides the register lag behind a write
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q <= 16'h0036;
      age_q <= 2'd3;
    end else begin
      if (wr_cfg) cfg_q <= pwdata_in[15:0];
      age_q <= wr_cfg ? 2'd0 : (ok ? age_q : age_q + 2'd1);
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  setup_answer_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no answer in access phase");
  nop_reads_zero_a: assert property (
    acc && !pwrite_in && paddr_in == 10'h000 |-> prdata_out == 32'h0)
    else $error("no-op read not zero");
  code_follows_a: assert property (
    acc && pwrite_in && paddr_in == 10'h004 |-> ##2 dac_code_out == $past(pwdata_in[15:0], 2))
    else $error("code output misses write");
  clk_held_low_a: assert property (
    ok && cfg_q[13:10] inside {4'h0, 4'hc, 4'hd, 4'he} |-> !clk_out)
    else $error("clock output not low");
  break_irq_off_a: assert property (ok && !cfg_q[9] |-> uart_tx_pin_out)
    else $error("uart line pulled while disabled");
  irq_pin_drive_a: assert property (ok |-> irq_oe_n_out == !cfg_q[8])
    else $error("irq pin enable wrong");
  async_off_a: assert property (ok |-> async_port_off_out == cfg_q[6])
    else $error("uart off wrong");
  frame_check_a: assert property (ok |-> frame_check_on_out == cfg_q[4])
    else $error("frame check enable wrong");
  sdo_float_a: assert property (ok && cfg_q[1] |-> sdo_oe_n_out)
    else $error("sdo driven while floating");
  sdo_edge_a: assert property (ok |-> sdo_early_out == cfg_q[0])
    else $error("sdo launch edge wrong");
  edge_pulse_a: assert property (
    ok && !cfg_q[2] && irq_out == cfg_q[3] |=> !ok || irq_out != cfg_q[3])
    else $error("edge irq longer than one cycle");
  bad_addr_err_a: assert property (psel_in && penable_in && paddr_in[1:0] != 2'b00 |-> pslverr_out)
    else $error("misaligned access not refused");
endmodule : dcr_bank_asserts
bind dcr_bank dcr_bank_asserts dcr_bank_asserts_i (.sys_clk_in, .nrst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .dac_code_out, .clk_out, .irq_out, .irq_oe_n_out, .uart_tx_pin_out, .async_port_off_out,
  .frame_check_on_out, .sdo_oe_n_out, .sdo_early_out);
`default_nettype wire

// file: tb/dcr_host_model.sv
// Purpose: Host side pins: SPI frames with check result, oscillator tick.
// Assumes: A frame is asked for by a one-cycle send pulse.
// Notes: Lines not carrying data toggle so no stale value can pass.
`timescale 1ns/1ps
`default_nettype none
module dcr_host_model (
  input wire logic clk_in,
  input wire logic send_in,
  input wire logic bad_in,
  output logic cs_n_out,
  output logic done_out,
  output logic bad_out,
  output logic sdo_out,
  output logic osc_out
);
  int ph = 0;
  logic [1:0] oc = 2'd0;
  initial begin
    cs_n_out = 1'b1;
    done_out = 1'b0;
    bad_out = 1'b0;
    sdo_out = 1'b0;
    osc_out = 1'b0;
  end
  // Free running tick, four system cycles a period
  always @(posedge clk_in) begin
    oc <= oc + 2'd1;
    osc_out <= oc[1];
  end
  // Select low six cycles, then the end marker carrying the check result
  always @(posedge clk_in) begin
    if (ph != 0 || send_in) ph <= (ph == 12) ? 0 : ph + 1;
    cs_n_out <= !(ph >= 1 && ph <= 6);
    done_out <= ph >= 7 && ph <= 10;
    bad_out <= (ph >= 6 && ph <= 10) ? bad_in : ~bad_out;
    sdo_out <= ~sdo_out;
  end
endmodule : dcr_host_model
`default_nettype wire

// file: tb/testbench.sv
// Purpose: Random and corner-case run of the setup bank over APB.
// Assumes: The slave answers with pready, the wait is bounded; pins settle within a few cycles.
// Notes: Clock output rate is judged on a window of eight periods.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, nrst, psel, penable, pwrite, send, bad, timer, ev, brk, clr, sdi;
  logic pready, pslverr, err, clk_o, irq, irq_oe_n, int_o, cs_n, fdone, fbad, sdo, osc, pv;
  logic tx, clr_o, sdo_oe_n, sdo_o;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] code, v;
  int num_errors, checks, n, cnt;
  dcr_bank dcr_bank_i (.sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .osc_tick_in(osc), .timer_in(timer),
    .frame_done_in(fdone), .frame_bad_in(fbad), .spi_clear_pin_in(clr), .sdi_in(sdi),
    .cs_n_in(cs_n), .uart_break_mode_in(brk), .ext_event_in(ev), .spi_sdo_in(sdo),
    .dac_code_out(code), .clk_out(clk_o), .irq_out(irq), .irq_oe_n_out(irq_oe_n),
    .uart_tx_pin_out(tx), .async_port_off_out(), .frame_check_on_out(), .clear_req_out(clr_o),
    .sdo_out(sdo_o), .sdo_oe_n_out(sdo_oe_n), .sdo_early_out(), .int_out(int_o));
  dcr_host_model dcr_host_model_i (.clk_in(clk), .send_in(send), .bad_in(bad),
    .cs_n_out(cs_n), .done_out(fdone), .bad_out(fbad), .sdo_out(sdo), .osc_out(osc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      summarize();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  task automatic frame(input logic b);
    @(posedge clk);
    send <= 1'b1;
    bad <= b;
    @(posedge clk);
    send <= 1'b0;
    repeat (16) @(posedge clk);
  endtask : frame
  // Setup word: irq pin on, reserved one, sdo floating, rising launch
  function automatic logic [31:0] cfgw(logic [1:0] t, logic [3:0] c, logic p, logic l, logic f);
    return {16'h0, t, c, 2'b01, 2'b00, 1'b1, f, p, l, 2'b10};
  endfunction : cfgw
  function automatic int period(logic [3:0] c);
    int d[11] = '{1, 2, 4, 8, 16, 32, 48, 128, 128, 512, 1024};
    return (c == 4'h1) ? 8 : 4 * d[c - 1];
  endfunction : period
  initial begin
    {psel, penable, pwrite, send, bad, timer, ev, brk, clr, sdi, nrst} = '0;
    paddr = 10'h0;
    pwdata = 32'h0;
    num_errors = 0;
    checks = 0;
    void'($urandom(9));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(10'h004, 32'h0, "code reset");
    rd(10'h008, 32'h36, "setup reset");
    chk("irq pin idle", 32'h1, irq_oe_n);
    // Random code, no-op and setup traffic
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      apb(1'b1, 10'h004, {16'($urandom), v});
      apb(1'b1, 10'h000, $urandom);
      rd(10'h000, 32'h0, "no-op");
      rd(10'h004, {16'h0, v}, "code");
      chk("code pins", {16'h0, v}, code);
      v = 16'($urandom) | 16'h0020;
      {ev, brk, clr, sdi} <= 4'($urandom);
      apb(1'b1, 10'h008, v);
      rd(10'h008, v, "setup");
    end
    ev <= 1'b0;
    apb(1'b0, 10'h03c, 32'h0);
    chk("unmapped refused", 32'h1, err);
    apb(1'b1, 10'h006, 32'h0);
    chk("misaligned refused", 32'h1, err);
    apb(1'b1, 10'h044, 32'h1);
    // Fault threshold per count, a good frame restarting the run
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, 10'h008, cfgw(2'(t), 4'h0, t[0], t[1], 1'b1));
      apb(1'b0, 10'h040, 32'h0);
      repeat ((1 << t) - 1) frame(1'b1);
      frame(1'b0);
      repeat ((1 << t) - 1) frame(1'b1);
      rd(10'h040, 32'h0, "fault early");
      frame(1'b1);
      chk("int raised", 32'h1, int_o);
      chk("irq pin on", 32'h0, irq_oe_n);
      chk("irq active", {31'h0, t[1] ? t[0] : !t[0]}, irq);
      apb(1'b0, 10'h040, 32'h0);
      chk("fault set", 32'h1, {31'h0, q[0]});
      repeat (4) @(posedge clk);
      chk("int cleared", 32'h0, int_o);
      chk("irq idle", {31'h0, !t[0]}, irq);
    end
    apb(1'b1, 10'h008, cfgw(2'h0, 4'h0, 1'b0, 1'b1, 1'b0));
    frame(1'b1);
    rd(10'h040, 32'h0, "check off");
    // Divided clock rate over eight periods
    for (int c = 1; c < 5; c++) begin
      apb(1'b1, 10'h008, cfgw(2'h0, 4'(c), 1'b0, 1'b1, 1'b1));
      repeat (40) @(posedge clk);
      cnt = 0;
      pv = clk_o;
      repeat (8 * period(4'(c))) begin
        @(posedge clk);
        if (clk_o && !pv) cnt++;
        pv = clk_o;
      end
      chk("clock rate", 32'h1, {31'h0, cnt >= 7 && cnt <= 9});
    end
    apb(1'b1, 10'h008, cfgw(2'h0, 4'hf, 1'b0, 1'b1, 1'b1));
    timer <= 1'b1;
    repeat (8) @(posedge clk);
    chk("timer high", 32'h1, clk_o);
    timer <= 1'b0;
    repeat (8) @(posedge clk);
    chk("timer low", 32'h0, clk_o);
    // Clear source per mode, break-mode interrupt on the UART line, pin readback
    {brk, clr, sdi} <= 3'b010;
    apb(1'b1, 10'h044, 32'h2);
    apb(1'b1, 10'h008, 32'h2a4);
    repeat (6) @(posedge clk);
    chk("clear from pin", 32'h1, clr_o);
    chk("tx idle in spi", 32'h1, tx);
    brk <= 1'b1;
    repeat (6) @(posedge clk);
    chk("clear from sdi low", 32'h0, clr_o);
    sdi <= 1'b1;
    repeat (6) @(posedge clk);
    chk("clear from sdi high", 32'h1, clr_o);
    chk("tx irq in break", 32'h0, tx);
    rd(10'h048, 32'h1c, "pin state");
    // SDO is driven only while chip select is low once the float bit is clear
    @(posedge clk);
    send <= 1'b1;
    repeat (7) @(posedge clk);
    send <= 1'b0;
    chk("sdo driven", 32'h0, sdo_oe_n);
    chk("sdo path", {31'h0, !sdo}, sdo_o);
    repeat (16) @(posedge clk);
    chk("sdo idle", 32'h1, sdo_oe_n);
    summarize();
  end
endmodule : testbench
`default_nettype wire
